// file: hdl/mcf_regs.svh
// Register map, field positions, reset values and timing counts of the
// monitor configuration and failsafe register bank.
// Assumes a 100 MHz core clock; included by bare name from hdl/.
//
// Function
// - Any processor reading above failsafe threshold forces every PWM to full duty.
// - Threshold value 0x80 disables the failsafe full-speed behaviour entirely.
// - Failsafe holds full duty until reading drops below threshold minus hysteresis.
// - Version register: revision in bits 1:0, family version in bits 7:4.
// - Version bits 2 and 3 read 1: thermal interface and 4-wire PWM support.
// - Run bit 1 monitors with programmed limits; 0 stops and selects defaults.
// - Clearing run leaves programmed limits intact for when monitoring resumes.
// - While run is 0, all PWM outputs drive full duty.
// - Lock bit accepts one write of 1, then lockable registers freeze until power cycle.
// - Run bit stays writable after locking.
// - Ready bit reads 1 once power-up completes.
// - Fan boost 1 forces full duty; 0 returns to automatic duty.
// - Fan boost stays writable after locking.
// - Processor thermal monitor bit enables monitoring; read-only after locking.
// - Override bit makes overtemp pin force full or maximum duty; maximum only while running without boost or failsafe.
// - Averaging field selects 4, 8, 16 or 32 readings per averaged value.
`ifndef MCF_REGS_SVH
`define MCF_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MCF_ADDR_THRESHOLD 8'h3d
`define MCF_ADDR_MAKER 8'h3e
`define MCF_ADDR_VERSION 8'h3f
`define MCF_ADDR_CONFIG 8'h40

// ----------------------------------------------------------------------
// Main configuration fields
// ----------------------------------------------------------------------
`define MCF_CFG_RUN 0
`define MCF_CFG_LOCK 1
`define MCF_CFG_READY 2
`define MCF_CFG_BOOST 3
`define MCF_CFG_CPU_MON 4
`define MCF_CFG_OT_OVR 5
`define MCF_CFG_AVG_HI 7
`define MCF_CFG_AVG_LO 6

// ----------------------------------------------------------------------
// Version and capability fields
// ----------------------------------------------------------------------
`define MCF_VERSION_CAP_CPU 2
`define MCF_VERSION_CAP_4WIRE 3

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define MCF_THRESHOLD_RESET 8'h00
`define MCF_THRESHOLD_OFF 8'h80
`define MCF_HYSTERESIS 9'h004
`define MCF_DUTY_FULL 8'hff
`define MCF_RDATA_NONE 8'h00
`define MCF_MAKER_CODE 8'h5a // Arbitrary value
`define MCF_REVISION 2'h1 // Arbitrary value
`define MCF_FAMILY 4'h3 // Arbitrary value
`define MCF_AVG_BASE 6'h04

// ----------------------------------------------------------------------
// Power-up time
// ----------------------------------------------------------------------
`define MCF_CLK_PERIOD_NS 10
`define MCF_READY_NS 1000
`define MCF_READY_CYCLES ((`MCF_READY_NS + `MCF_CLK_PERIOD_NS - 1) / `MCF_CLK_PERIOD_NS)

`endif

// file: hdl/mcf_pkg.sv
// Types used by the register bank; its failsafe comparator uses none of them.
// Assumes mcf_regs.svh provides all numeric constants.
package mcf_pkg;

  // Power-up sequencing of the bank
  typedef enum logic [0:0] {
    MCF_PWR_WAIT,
    MCF_PWR_READY
  } mcf_pwr_state_t;

  // Which source sets the PWM duty this cycle
  typedef enum logic [2:0] {
    MCF_DUTY_AUTO,
    MCF_DUTY_DEFAULT_FULL,
    MCF_DUTY_FORCED_FULL,
    MCF_DUTY_OVERTEMP_MAX
  } mcf_duty_src_t;

endpackage

// file: hdl/mcf_failsafe.sv
// Failsafe comparator: processor reading against the threshold with a
// fixed hysteresis band. Readings are signed 8-bit degrees.
// Assumes o_active is sampled by the register bank one cycle later.
`timescale 1ns/10ps
`include "mcf_regs.svh"

module mcf_failsafe (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_temp_valid,
  input wire logic [7:0] i_temp,
  input wire logic [7:0] i_threshold,
  output logic o_active
);

  logic active_r;
  logic active_nxt;
  logic signed [8:0] temp_s;
  logic signed [8:0] thr_s;
  logic signed [8:0] release_s;

  // ----------------------------------------------------------------------
  // Compare and hysteresis
  // ----------------------------------------------------------------------
  // Nine bits keep threshold minus hysteresis from wrapping near -128
  always_comb begin
    temp_s = {i_temp[7], i_temp};
    thr_s = {i_threshold[7], i_threshold};
    release_s = thr_s - $signed(`MCF_HYSTERESIS);
    active_nxt = active_r;
    if (i_threshold == `MCF_THRESHOLD_OFF) begin
      active_nxt = 1'b0;
    end else if (i_temp_valid) begin
      if (temp_s > thr_s) begin
        active_nxt = 1'b1;
      end else if (temp_s < release_s) begin
        active_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      active_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
    end
  end

  assign o_active = active_r;

endmodule

// file: hdl/mcf_config_regs.sv
// Configuration, identification and failsafe registers of the monitor.
// Assumes the serial slave engine presents single-cycle read and write
// strobes with an 8-bit register address, synchronous to i_clk.
`timescale 1ns/10ps
`include "mcf_regs.svh"

module mcf_config_regs (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_cpu_temp_valid,
  input wire logic [7:0] i_cpu_temp,
  input wire logic i_overtemp_pin_n,
  input wire logic i_overtemp_use_max,
  input wire logic [7:0] i_max_duty,
  input wire logic [7:0] i_auto_duty,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  output logic [7:0] o_pwm_duty,
  output logic o_monitor_run,
  output logic o_use_default_limits,
  output logic o_limits_locked,
  output logic o_cpu_monitor_en,
  output logic [1:0] o_average_length_sel,
  output logic [5:0] o_average_count,
  output logic o_ready
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Readings per averaged value: 4 shifted by the select field
  function automatic logic [5:0] avg_count(input logic [1:0] sel);
    avg_count = `MCF_AVG_BASE << sel;
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam int READY_CYC = `MCF_READY_CYCLES;

  mcf_pkg::mcf_pwr_state_t pwr_r;
  mcf_pkg::mcf_pwr_state_t pwr_nxt;
  logic [7:0] pwr_cnt_r;
  logic [7:0] pwr_cnt_nxt;
  logic [7:0] thr_r;
  logic [7:0] thr_nxt;
  logic run_r;
  logic run_nxt;
  logic lock_r;
  logic lock_nxt;
  logic boost_r;
  logic boost_nxt;
  logic cpu_mon_r;
  logic cpu_mon_nxt;
  logic ot_ovr_r;
  logic ot_ovr_nxt;
  logic [1:0] avg_r;
  logic [1:0] avg_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic [7:0] duty_r;
  logic [7:0] duty_nxt;
  mcf_pkg::mcf_duty_src_t duty_src;
  logic fs_active;
  logic [7:0] version_val;
  logic [7:0] config_val;

  // ----------------------------------------------------------------------
  // Failsafe comparator
  // ----------------------------------------------------------------------
  mcf_failsafe u_failsafe (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_temp_valid(i_cpu_temp_valid),
    .i_temp(i_cpu_temp),
    .i_threshold(thr_r),
    .o_active(fs_active)
  );

  // ----------------------------------------------------------------------
  // Power-up sequencing
  // ----------------------------------------------------------------------
  // Ready only after the settle count, so software never sees a half-up bank
  always_comb begin
    pwr_nxt = pwr_r;
    pwr_cnt_nxt = pwr_cnt_r;
    case (pwr_r)
      mcf_pkg::MCF_PWR_WAIT: begin
        if (pwr_cnt_r == 8'(READY_CYC - 1)) begin
          pwr_nxt = mcf_pkg::MCF_PWR_READY;
        end else begin
          pwr_cnt_nxt = pwr_cnt_r + 8'h01;
        end
      end
      mcf_pkg::MCF_PWR_READY: begin
        pwr_nxt = mcf_pkg::MCF_PWR_READY;
      end
      default: begin
        pwr_nxt = mcf_pkg::MCF_PWR_WAIT;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_r <= mcf_pkg::MCF_PWR_WAIT;
      pwr_cnt_r <= 8'h00;
    end else begin
      pwr_r <= pwr_nxt;
      pwr_cnt_r <= pwr_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Locked fields simply keep their value; no error is flagged to the master
  always_comb begin
    thr_nxt = thr_r;
    run_nxt = run_r;
    lock_nxt = lock_r;
    boost_nxt = boost_r;
    cpu_mon_nxt = cpu_mon_r;
    ot_ovr_nxt = ot_ovr_r;
    avg_nxt = avg_r;
    if (i_wr_en && hit(i_addr, `MCF_ADDR_THRESHOLD) && !lock_r) begin
      thr_nxt = i_wdata;
    end
    if (i_wr_en && hit(i_addr, `MCF_ADDR_CONFIG)) begin
      run_nxt = i_wdata[`MCF_CFG_RUN];
      boost_nxt = i_wdata[`MCF_CFG_BOOST];
      lock_nxt = lock_r | i_wdata[`MCF_CFG_LOCK];
      if (!lock_r) begin
        cpu_mon_nxt = i_wdata[`MCF_CFG_CPU_MON];
        ot_ovr_nxt = i_wdata[`MCF_CFG_OT_OVR];
        avg_nxt = i_wdata[`MCF_CFG_AVG_HI:`MCF_CFG_AVG_LO];
      end
    end
  end

  // Threshold is untouched by run changes, so it returns when monitoring resumes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      thr_r <= `MCF_THRESHOLD_RESET;
      run_r <= 1'b0;
      lock_r <= 1'b0;
      boost_r <= 1'b0;
      cpu_mon_r <= 1'b0;
      ot_ovr_r <= 1'b0;
      avg_r <= 2'h0;
    end else begin
      thr_r <= thr_nxt;
      run_r <= run_nxt;
      lock_r <= lock_nxt;
      boost_r <= boost_nxt;
      cpu_mon_r <= cpu_mon_nxt;
      ot_ovr_r <= ot_ovr_nxt;
      avg_r <= avg_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_comb begin
    version_val = {`MCF_FAMILY, 1'b1, 1'b1, `MCF_REVISION};
    config_val = {avg_r, ot_ovr_r, cpu_mon_r, boost_r,
                  pwr_r == mcf_pkg::MCF_PWR_READY, lock_r, run_r};
    rd_valid_nxt = i_rd_en;
    rdata_nxt = rdata_r;
    if (i_rd_en) begin
      case (i_addr)
        `MCF_ADDR_THRESHOLD: rdata_nxt = thr_r;
        `MCF_ADDR_MAKER: rdata_nxt = `MCF_MAKER_CODE;
        `MCF_ADDR_VERSION: rdata_nxt = version_val;
        `MCF_ADDR_CONFIG: rdata_nxt = config_val;
        default: rdata_nxt = `MCF_RDATA_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // PWM duty selection
  // ----------------------------------------------------------------------
  // Overtemp max duty loses to any full-duty cause, since full is the safer
  always_comb begin
    if (boost_r) begin
      duty_src = mcf_pkg::MCF_DUTY_FORCED_FULL;
    end else if (!run_r) begin
      duty_src = mcf_pkg::MCF_DUTY_DEFAULT_FULL;
    end else if (fs_active) begin
      duty_src = mcf_pkg::MCF_DUTY_FORCED_FULL;
    end else if (ot_ovr_r && !i_overtemp_pin_n) begin
      duty_src = i_overtemp_use_max ? mcf_pkg::MCF_DUTY_OVERTEMP_MAX
                                    : mcf_pkg::MCF_DUTY_FORCED_FULL;
    end else begin
      duty_src = mcf_pkg::MCF_DUTY_AUTO;
    end
    case (duty_src)
      mcf_pkg::MCF_DUTY_AUTO: duty_nxt = i_auto_duty;
      mcf_pkg::MCF_DUTY_OVERTEMP_MAX: duty_nxt = i_max_duty;
      default: duty_nxt = `MCF_DUTY_FULL;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= `MCF_RDATA_NONE;
      rd_valid_r <= 1'b0;
      duty_r <= `MCF_DUTY_FULL;
    end else begin
      rdata_r <= rdata_nxt;
      rd_valid_r <= rd_valid_nxt;
      duty_r <= duty_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Status flags get their own flops so no output leaves through a gate
  logic use_def_r;
  logic use_def_nxt;
  logic ready_r;
  logic ready_nxt;
  logic [5:0] avg_cnt_r;
  logic [5:0] avg_cnt_nxt;

  // Next values follow the next state, so the flags never lag their source
  always_comb begin
    use_def_nxt = !run_nxt;
    ready_nxt = (pwr_nxt == mcf_pkg::MCF_PWR_READY);
    avg_cnt_nxt = avg_count(avg_nxt);
  end

  // Registered count follows the select with no extra lag beyond avg_r
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      use_def_r <= 1'b1;
      ready_r <= 1'b0;
      avg_cnt_r <= `MCF_AVG_BASE;
    end else begin
      use_def_r <= use_def_nxt;
      ready_r <= ready_nxt;
      avg_cnt_r <= avg_cnt_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rd_valid = rd_valid_r;
  assign o_pwm_duty = duty_r;
  assign o_monitor_run = run_r;
  assign o_use_default_limits = use_def_r;
  assign o_limits_locked = lock_r;
  assign o_cpu_monitor_en = cpu_mon_r;
  assign o_average_length_sel = avg_r;
  assign o_ready = ready_r;
  assign o_average_count = avg_cnt_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  boost_full_a: assert property (boost_r |=> o_pwm_duty == `MCF_DUTY_FULL)
    else $error("boost did not force full duty");
  stop_full_a: assert property (!run_r |=> o_pwm_duty == `MCF_DUTY_FULL)
    else $error("stopped monitor did not force full duty");
  failsafe_full_a: assert property (fs_active |=> o_pwm_duty == `MCF_DUTY_FULL)
    else $error("failsafe did not force full duty");
  failsafe_off_a: assert property ((thr_r == `MCF_THRESHOLD_OFF)[*2] |-> !fs_active)
    else $error("failsafe active while disabled");
  lock_sticky_a: assert property (lock_r |=> lock_r)
    else $error("lock bit cleared");
  locked_thr_a: assert property (lock_r && i_wr_en && hit(i_addr, `MCF_ADDR_THRESHOLD)
      |=> $stable(thr_r))
    else $error("locked threshold changed");
  locked_fields_a: assert property (lock_r && i_wr_en |=> $stable(cpu_mon_r)
      && $stable(ot_ovr_r) && $stable(avg_r))
    else $error("locked config field changed");
  run_writable_a: assert property (lock_r && i_wr_en && hit(i_addr, `MCF_ADDR_CONFIG)
      |=> run_r == $past(i_wdata[`MCF_CFG_RUN]) && boost_r == $past(i_wdata[`MCF_CFG_BOOST]))
    else $error("run or boost not writable after lock");
  version_read_a: assert property (i_rd_en && hit(i_addr, `MCF_ADDR_VERSION)
      |=> o_rd_valid && o_rdata[`MCF_VERSION_CAP_4WIRE:`MCF_VERSION_CAP_CPU] == 2'h3)
    else $error("version capability bits wrong");
  ready_time_a: assert property ($rose(o_ready) |-> pwr_cnt_r == 8'(READY_CYC - 1))
    else $error("ready raised at wrong count");
  default_limits_a: assert property (o_use_default_limits == !o_monitor_run)
    else $error("default limit flag disagrees with run bit");
  overtemp_a: assert property (run_r && !boost_r && !fs_active && ot_ovr_r
      && !i_overtemp_pin_n && i_overtemp_use_max |=> o_pwm_duty == $past(i_max_duty))
    else $error("overtemp did not select max duty");
  avg_count_a: assert property (##1 o_average_count == avg_count(avg_r))
    else $error("averaging count mismatch");

  lock_seen_c: cover property ($rose(lock_r));
  failsafe_seen_c: cover property ($rose(fs_active) ##[1:50] $fell(fs_active));
  boost_locked_c: cover property (lock_r && $fell(boost_r));
  overtemp_seen_c: cover property (ot_ovr_r && !i_overtemp_pin_n && run_r);

endmodule

// file: tb/test_monitor_config_failsafe_regs.sv
// Self-checking bench for the configuration and failsafe register bank.
// Assumes hdl/ is on the include path and the design files compile first.
`timescale 1ns/10ps
`include "mcf_regs.svh"

`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("ERROR %0t: got %h want %h", $time, got, exp); \
  end \
end

module test_monitor_config_failsafe_regs;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_cpu_temp_valid = 1'b0;
  logic [7:0] i_cpu_temp = 8'h00;
  logic i_overtemp_pin_n = 1'b1;
  logic i_overtemp_use_max = 1'b0;
  logic [7:0] i_max_duty = 8'h00;
  logic [7:0] i_auto_duty = 8'h00;
  logic [7:0] o_rdata;
  logic o_rd_valid;
  logic [7:0] o_pwm_duty;
  logic o_monitor_run;
  logic o_use_default_limits;
  logic o_limits_locked;
  logic o_cpu_monitor_en;
  logic [1:0] o_average_length_sel;
  logic [5:0] o_average_count;
  logic o_ready;
  int fails = 0;
  int checks = 0;
  int seed = 50;
  logic [7:0] v;
  logic [7:0] r;
  logic [7:0] aut;

  // ----------------------------------------------------------------------
  // Clock and design
  // ----------------------------------------------------------------------
  // 100 MHz core clock
  always #5 i_clk = ~i_clk;

  mcf_config_regs DUT (.i_clk(i_clk), .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_cpu_temp_valid(i_cpu_temp_valid),
    .i_cpu_temp(i_cpu_temp), .i_overtemp_pin_n(i_overtemp_pin_n),
    .i_overtemp_use_max(i_overtemp_use_max), .i_max_duty(i_max_duty),
    .i_auto_duty(i_auto_duty), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
    .o_pwm_duty(o_pwm_duty), .o_monitor_run(o_monitor_run),
    .o_use_default_limits(o_use_default_limits), .o_limits_locked(o_limits_locked),
    .o_cpu_monitor_en(o_cpu_monitor_en), .o_average_length_sel(o_average_length_sel),
    .o_average_count(o_average_count), .o_ready(o_ready));

  // ----------------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------------
  // Version word: family on top, both capability flags set, revision below
  function automatic logic [7:0] exp_version();
    return {`MCF_FAMILY, 1'b1, 1'b1, `MCF_REVISION};
  endfunction

  // Readings per averaged value double with each step of the field
  function automatic logic [5:0] exp_count(input logic [1:0] sel);
    return 6'h04 << sel;
  endfunction

  // Inputs move 1 ns after the edge so no race with the design's flops
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    i_wr_en = 1'b1;
    i_addr = a;
    i_wdata = d;
    tick(1);
    i_wr_en = 1'b0;
  endtask

  // Read strobe is one cycle; data and valid are sampled the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    i_rd_en = 1'b1;
    i_addr = a;
    tick(1);
    i_rd_en = 1'b0;
    `CHK(o_rd_valid, 1'b1)
    d = o_rdata;
  endtask

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    i_rst = 1'b1;
    repeat (6) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
  endtask

  // Bounded wait so a ready flag that never rises cannot hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n >= 200) begin
      fails++;
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    `CHK(o_pwm_duty, `MCF_DUTY_FULL)
    `CHK(o_use_default_limits, 1'b1)
    tick(90);
    `CHK(o_ready, 1'b0)
    wait_ready();
    `CHK(o_ready, 1'b1)
    rd(`MCF_ADDR_CONFIG, v);
    `CHK(v, 8'h04)
    rd(`MCF_ADDR_VERSION, v);
    `CHK(v, exp_version())
    `CHK(v[3:2], 2'b11)
    // Identity and version are read-only; unmapped reads give zero
    wr(`MCF_ADDR_VERSION, 8'h00);
    wr(`MCF_ADDR_MAKER, 8'h00);
    rd(`MCF_ADDR_VERSION, v);
    `CHK(v, exp_version())
    rd(`MCF_ADDR_MAKER, v);
    `CHK(v, `MCF_MAKER_CODE)
    rd(8'h41, v);
    `CHK(v, 8'h00)
    rd(`MCF_ADDR_THRESHOLD, v);
    `CHK(v, `MCF_THRESHOLD_RESET)
    // Random thresholds, every averaging code, random automatic duty
    for (int i = 0; i < 16; i++) begin
      v = 8'($random(seed));
      wr(`MCF_ADDR_THRESHOLD, v);
      rd(`MCF_ADDR_THRESHOLD, r);
      `CHK(r, v)
      aut = {1'b0, 7'($random(seed))};
      i_auto_duty = aut;
      wr(`MCF_ADDR_CONFIG, {2'(i), 6'h01});
      tick(2);
      `CHK(o_average_count, exp_count(2'(i)))
      `CHK(o_average_length_sel, 2'(i))
      `CHK(o_pwm_duty, aut)
    end
    // Boost overrides, then hands back the automatic duty
    wr(`MCF_ADDR_CONFIG, 8'h09);
    tick(2);
    `CHK(o_pwm_duty, `MCF_DUTY_FULL)
    wr(`MCF_ADDR_CONFIG, 8'h01);
    tick(2);
    `CHK(o_pwm_duty, aut)
    wr(`MCF_ADDR_CONFIG, 8'h00);
    tick(2);
    `CHK(o_pwm_duty, `MCF_DUTY_FULL)
    `CHK(o_use_default_limits, 1'b1)
    // Failsafe: trip strictly above, hold inside the hysteresis band
    wr(`MCF_ADDR_THRESHOLD, 8'h50);
    wr(`MCF_ADDR_CONFIG, 8'h01);
    i_cpu_temp_valid = 1'b1;
    i_cpu_temp = 8'h50;
    tick(3);
    `CHK(o_pwm_duty, aut)
    i_cpu_temp = 8'h51;
    tick(3);
    `CHK(o_pwm_duty, `MCF_DUTY_FULL)
    i_cpu_temp = 8'h4c;
    tick(3);
    `CHK(o_pwm_duty, `MCF_DUTY_FULL)
    wr(`MCF_ADDR_CONFIG, 8'h00);
    wr(`MCF_ADDR_CONFIG, 8'h01);
    rd(`MCF_ADDR_THRESHOLD, v);
    `CHK(v, 8'h50)
    `CHK(o_pwm_duty, `MCF_DUTY_FULL)
    i_cpu_temp = 8'h4b;
    tick(3);
    `CHK(o_pwm_duty, aut)
    // 0x80 disables the failsafe even though it reads as the lowest value
    i_cpu_temp = 8'h7f;
    tick(3);
    `CHK(o_pwm_duty, `MCF_DUTY_FULL)
    wr(`MCF_ADDR_THRESHOLD, `MCF_THRESHOLD_OFF);
    tick(3);
    `CHK(o_pwm_duty, aut)
    // Overtemp pin with override enabled selects maximum or full duty
    i_max_duty = aut ^ 8'h2a;
    i_overtemp_use_max = 1'b1;
    i_overtemp_pin_n = 1'b0;
    wr(`MCF_ADDR_CONFIG, 8'h21);
    tick(2);
    `CHK(o_pwm_duty, aut ^ 8'h2a)
    i_overtemp_use_max = 1'b0;
    tick(2);
    `CHK(o_pwm_duty, `MCF_DUTY_FULL)
    wr(`MCF_ADDR_CONFIG, 8'h01);
    tick(2);
    `CHK(o_pwm_duty, aut)
    i_overtemp_pin_n = 1'b1;
    // Lock: later writes only reach run and boost
    wr(`MCF_ADDR_CONFIG, 8'hd3);
    rd(`MCF_ADDR_CONFIG, v);
    `CHK(v, 8'hd7)
    wr(`MCF_ADDR_CONFIG, 8'h28);
    rd(`MCF_ADDR_CONFIG, v);
    `CHK(v, 8'hde)
    `CHK(o_limits_locked, 1'b1)
    `CHK(o_cpu_monitor_en, 1'b1)
    `CHK(o_monitor_run, 1'b0)
    `CHK(o_pwm_duty, `MCF_DUTY_FULL)
    wr(`MCF_ADDR_THRESHOLD, 8'h33);
    rd(`MCF_ADDR_THRESHOLD, v);
    `CHK(v, `MCF_THRESHOLD_OFF)
    wr(`MCF_ADDR_CONFIG, 8'h01);
    rd(`MCF_ADDR_CONFIG, v);
    `CHK(v, 8'hd7)
    // Only a reset removes the lock
    do_reset();
    `CHK(o_limits_locked, 1'b0)
    rd(`MCF_ADDR_THRESHOLD, v);
    `CHK(v, `MCF_THRESHOLD_RESET)
    end_of_test();
  end
endmodule
